// [core/adc_scan_pkg.sv]
// constants, register map and state codes for the converter scan sequencer
// assumes one 20 MHz system clock and a 1 MHz converter clock derived from it
package adc_scan_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NCH = 7;
  localparam int RES_W = 10;
  localparam int SEL_W = 3;
  localparam int AVG_W = 3;
  localparam int ACC_W = 17;
  localparam int PASS_W = 8;
  localparam int SLOT_W = 9;
  localparam int DIV_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // channel select codes on the input multiplexer
  localparam logic [2:0] CH_SUPPLY_VOLT = 3'h0;
  localparam logic [2:0] CH_SUPPLY_CURR = 3'h1;
  localparam logic [2:0] CH_BATTERY_VOLT = 3'h2;
  localparam logic [2:0] CH_AUX_SENSE_A = 3'h3;
  localparam logic [2:0] CH_AUX_SENSE_B = 3'h4;
  localparam logic [2:0] CH_LEFT_SWITCH = 3'h5;
  localparam logic [2:0] CH_RIGHT_SWITCH = 3'h6;
  localparam logic [2:0] CH_LAST = CH_RIGHT_SWITCH;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHAN_EN = 8'h01;
  localparam logic [7:0] OFF_AVG = 8'h02;
  localparam logic [7:0] OFF_STATUS = 8'h03;
  localparam logic [7:0] OFF_RESULT0 = 8'h08;

  // control fields
  localparam int CTRL_SCAN_BIT = 0;
  localparam int CTRL_SRC_A_BIT = 1;
  localparam int CTRL_SRC_B_BIT = 2;
  localparam int CTRL_SRC_B_HI_BIT = 3;
  localparam int CTRL_W = 4;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LEFT_BIT = 1;
  localparam int STAT_RIGHT_BIT = 2;
  localparam int STAT_BOOST_BIT = 3;
  localparam int STAT_DONE_BIT = 4;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [6:0] CHAN_EN_RST = 7'h7F;
  localparam logic [2:0] AVG_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int MCLK_HZ = 20_000_000;
  localparam int CONV_CLK_HZ = 1_000_000;
  localparam int SLOT_CONV_CYCLES = 14;
  localparam int MCLK_PER_CONV = MCLK_HZ / CONV_CLK_HZ;
  localparam int CONV_HALF_MCLK = MCLK_PER_CONV / 2;
  localparam int SLOT_MCLK = SLOT_CONV_CYCLES * MCLK_PER_CONV;
  localparam logic [8:0] SLOT_LAST = 9'(SLOT_MCLK - 1);
  localparam logic [3:0] DIV_LAST = 4'(CONV_HALF_MCLK - 1);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_COMMIT = 3'b100
  } scan_state_t;

endpackage : adc_scan_pkg

// [core/chan_accum.sv]
// one channel's sample accumulator and averaging shifter
// assumes the sequencer raises add only in the last cycle of a slot
`timescale 1ns/10ps
module chan_accum #(
  parameter logic [2:0] CH_ID = 3'h0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control from sequencer
  input wire logic clr,
  input wire logic add,
  input wire logic [adc_scan_pkg::SEL_W-1:0] sel,
  input wire logic [adc_scan_pkg::RES_W-1:0] sample,
  input wire logic [adc_scan_pkg::AVG_W-1:0] shift,
  // averaged value
  output logic [adc_scan_pkg::RES_W-1:0] avg
);
  import adc_scan_pkg::*;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  wire logic hit_w = add && (sel == CH_ID);

  ////////////////////////////////////////////////////////////////////////////
  // accumulate, clear wins
  assign acc_next = clr ? '0 : (hit_w ? acc_reg + ACC_W'(sample) : acc_reg); // see R12
  assign avg = RES_W'(acc_reg >> shift); // see R12

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  a_acc_sum: assert property (@(posedge mclk) disable iff (!rst_n) // see R12
    (hit_w && !clr) |=> acc_reg == $past(acc_reg) + ACC_W'($past(sample)))
    else $error("accumulator did not add the sample");

endmodule : chan_accum

// [core/adc_scan_sequencer.sv]
// scan sequencer, averaging and result registers for a 10-bit converter
// assumes the analog core converts the selected input over one 14-clock slot
// and holds its result on conv_data in the last system cycle of that slot
//
// Behaviour
// R01 - up to seven channels are converted at 10 bits and all results are published together after a full scan.
// R02 - each channel has its own readable register holding an unsigned 10-bit raw value.
// R03 - the channels are supply voltage, supply current, battery voltage, two aux sense inputs and two switch senses.
// R04 - the converter clock is 1 MHz and each result takes 14 of its cycles.
// R05 - only enabled channels are converted, so refresh time scales with channels times averaging count.
// R06 - a programmable number of samples, up to 128, is averaged before results are updated.
// R07 - a software-enabled 20 uA source on aux sense input a may stay on during its conversion.
// R08 - a 20 uA or 100 uA source on aux sense input b may run during its conversion.
// R09 - each low-side switch has a light-load flag set when its current is below 4 mA.
// R10 - a readable boost light-load flag is set when output load current is below the threshold.
// R11 - enabled channels are visited round robin, skipping disabled ones, restarting after the last.
// R12 - each average is the sum of the samples divided by the count, truncated to 10 bits.
`timescale 1ns/10ps
module adc_scan_sequencer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [adc_scan_pkg::ADDR_W-1:0] addr,
  input wire logic [adc_scan_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [adc_scan_pkg::DATA_W-1:0] rdata,
  // analog converter core
  output logic conv_clk,
  output logic conv_start,
  output logic [adc_scan_pkg::SEL_W-1:0] chan_sel,
  input wire logic [adc_scan_pkg::RES_W-1:0] conv_data,
  // current sources on the sense pins
  output logic aux_sense_a_src_en,
  output logic aux_sense_b_src_en,
  output logic aux_sense_b_src_hi,
  // load comparators
  input wire logic left_light_cmp,
  input wire logic right_light_cmp,
  input wire logic boost_light_cmp,
  // scan status
  output logic scan_busy,
  output logic results_updated
);
  import adc_scan_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // next enabled channel after cur; top bit flags a wrap to the scan start
  function automatic logic [3:0] next_chan(input logic [NCH-1:0] mask, input logic [2:0] cur);
    logic [3:0] r;
    logic [2:0] idx;
    logic found;
    r = {1'b1, cur};
    found = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      idx = 3'((int'(cur) + i) % NCH);
      if (!found && mask[idx]) begin
        found = 1'b1;
        r = {(idx <= cur), idx};
      end
    end
    return r;
  endfunction : next_chan

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [CTRL_W-1:0] ctrl_reg;
  logic [NCH-1:0] chan_en_reg;
  logic [AVG_W-1:0] avg_reg;
  logic [2:0] light_reg;
  logic done_flag_reg;
  scan_state_t state_reg;
  scan_state_t state_next;
  logic [NCH-1:0] scan_mask_reg;
  logic [AVG_W-1:0] scan_avg_reg;
  logic [SEL_W-1:0] chan_sel_reg;
  logic [SEL_W-1:0] chan_sel_next;
  logic [SLOT_W-1:0] slot_cnt_reg;
  logic [SLOT_W-1:0] slot_cnt_next;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [DIV_W-1:0] div_cnt_next;
  logic conv_clk_reg;
  logic conv_clk_next;
  logic conv_start_reg;
  logic [PASS_W-1:0] pass_cnt_reg;
  logic [PASS_W-1:0] pass_cnt_next;
  logic [RES_W-1:0] result_reg [NCH];
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic src_a_reg;
  logic src_b_reg;
  logic src_b_hi_reg;
  logic busy_reg;
  logic upd_reg;
  logic [RES_W-1:0] avg_w [NCH];

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire logic wr_ctrl_w = wr && (addr == OFF_CTRL);
  wire logic wr_chan_w = wr && (addr == OFF_CHAN_EN);
  wire logic wr_avg_w = wr && (addr == OFF_AVG);
  wire logic wr_stat_w = wr && (addr == OFF_STATUS);
  wire logic [ADDR_W-1:0] res_idx_w = addr - OFF_RESULT0;
  wire logic res_hit_w = (addr >= OFF_RESULT0) && (res_idx_w < ADDR_W'(NCH));
  wire logic [2:0] light_clr_w = wr_stat_w ? {wdata[STAT_BOOST_BIT], wdata[STAT_RIGHT_BIT], wdata[STAT_LEFT_BIT]}
                                           : 3'h0;
  wire logic done_clr_w = wr_stat_w && wdata[STAT_DONE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // sequencing terms
  wire logic in_conv_w = (state_reg == ST_CONV);
  wire logic slot_last_w = in_conv_w && (slot_cnt_reg == SLOT_LAST); // see R04
  wire logic [3:0] nxt_w = next_chan(scan_mask_reg, chan_sel_reg); // see R11
  wire logic wrap_w = nxt_w[3];
  wire logic [PASS_W-1:0] pass_target_w = PASS_W'(9'h001 << scan_avg_reg) - 8'h01; // see R06
  wire logic pass_last_w = (pass_cnt_reg == pass_target_w);
  wire logic scan_end_w = slot_last_w && wrap_w && pass_last_w; // see R05
  wire logic can_start_w = ctrl_reg[CTRL_SCAN_BIT] && (|chan_en_reg);
  wire logic launch_w = ((state_reg == ST_IDLE) || (state_reg == ST_COMMIT)) && can_start_w;
  wire logic [3:0] first_w = next_chan(chan_en_reg, CH_LAST); // see R11
  wire logic slot_begin_w = launch_w || (slot_last_w && !scan_end_w);

  ////////////////////////////////////////////////////////////////////////////
  // state and counters
  assign state_next = launch_w ? ST_CONV :
                      scan_end_w ? ST_COMMIT :
                      (state_reg == ST_COMMIT) ? ST_IDLE : state_reg;
  assign chan_sel_next = launch_w ? first_w[2:0] :
                         slot_last_w ? nxt_w[2:0] : chan_sel_reg; // see R11
  assign slot_cnt_next = slot_begin_w ? '0 :
                         in_conv_w ? slot_cnt_reg + 9'h001 : slot_cnt_reg;
  assign pass_cnt_next = launch_w ? '0 :
                         (slot_last_w && wrap_w) ? pass_cnt_reg + 8'h01 : pass_cnt_reg; // see R05
  assign div_cnt_next = (launch_w || !in_conv_w || div_cnt_reg == DIV_LAST) ? '0 : div_cnt_reg + 4'h1;
  assign conv_clk_next = launch_w ? 1'b0 :
                         (in_conv_w && div_cnt_reg == DIV_LAST) ? !conv_clk_reg : conv_clk_reg; // see R04

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      chan_sel_reg <= CH_SUPPLY_VOLT;
      slot_cnt_reg <= '0;
      pass_cnt_reg <= '0;
      div_cnt_reg <= '0;
      conv_clk_reg <= 1'b0;
      conv_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      chan_sel_reg <= chan_sel_next;
      slot_cnt_reg <= slot_cnt_next;
      pass_cnt_reg <= pass_cnt_next;
      div_cnt_reg <= div_cnt_next;
      conv_clk_reg <= conv_clk_next;
      conv_start_reg <= slot_begin_w;
    end
  end

  // scan set is frozen at launch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scan_mask_reg <= '0;
      scan_avg_reg <= '0;
    end else if (launch_w) begin
      scan_mask_reg <= chan_en_reg; // see R05
      scan_avg_reg <= avg_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel accumulators
  for (genvar g = 0; g < NCH; g++) begin : g_acc
    chan_accum #(.CH_ID(3'(g))) u_acc (
      .mclk(mclk),
      .rst_n(rst_n),
      .clr(launch_w),
      .add(slot_last_w),
      .sel(chan_sel_reg),
      .sample(conv_data),
      .shift(scan_avg_reg),
      .avg(avg_w[g])
    );
  end

  // results of all scanned channels published in one cycle once the scan completes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        result_reg[i] <= '0;
      end
    end else if (state_reg == ST_COMMIT) begin
      for (int i = 0; i < NCH; i++) begin
        if (scan_mask_reg[i]) begin
          result_reg[i] <= avg_w[i]; // see R01
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      chan_en_reg <= CHAN_EN_RST;
      avg_reg <= AVG_RST;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_reg <= wdata[CTRL_W-1:0];
      end
      if (wr_chan_w) begin
        chan_en_reg <= wdata[NCH-1:0];
      end
      if (wr_avg_w) begin
        avg_reg <= wdata[AVG_W-1:0];
      end
    end
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      light_reg <= 3'h0;
      done_flag_reg <= 1'b0;
    end else begin
      light_reg <= (light_reg & ~light_clr_w) | {boost_light_cmp, right_light_cmp, left_light_cmp}; // see R09 see R10
      done_flag_reg <= (done_flag_reg && !done_clr_w) || (state_reg == ST_COMMIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, data valid the cycle after the strobe only
  wire logic [DATA_W-1:0] status_w = DATA_W'({done_flag_reg, light_reg, busy_reg});
  assign rdata_next = !rd ? '0 :
                      (addr == OFF_CTRL) ? DATA_W'(ctrl_reg) :
                      (addr == OFF_CHAN_EN) ? DATA_W'(chan_en_reg) :
                      (addr == OFF_AVG) ? DATA_W'(avg_reg) :
                      (addr == OFF_STATUS) ? status_w :
                      res_hit_w ? DATA_W'(result_reg[res_idx_w[2:0]]) : '0; // see R02

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
      src_a_reg <= 1'b0;
      src_b_reg <= 1'b0;
      src_b_hi_reg <= 1'b0;
      busy_reg <= 1'b0;
      upd_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      src_a_reg <= ctrl_reg[CTRL_SRC_A_BIT]; // see R07
      src_b_reg <= ctrl_reg[CTRL_SRC_B_BIT]; // see R08
      src_b_hi_reg <= ctrl_reg[CTRL_SRC_B_HI_BIT]; // see R08
      busy_reg <= (state_next != ST_IDLE);
      upd_reg <= (state_reg == ST_COMMIT); // see R01
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata = rdata_reg;
  assign conv_clk = conv_clk_reg;
  assign conv_start = conv_start_reg;
  assign chan_sel = chan_sel_reg; // see R03
  assign aux_sense_a_src_en = src_a_reg;
  assign aux_sense_b_src_en = src_b_reg;
  assign aux_sense_b_src_hi = src_b_hi_reg;
  assign scan_busy = busy_reg;
  assign results_updated = upd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_slot_open;
    conv_start_reg;
  endsequence

  sequence s_scan_close;
    slot_last_w && wrap_w && pass_last_w;
  endsequence

  a_slot_length: assert property (@(posedge mclk) disable iff (!rst_n) // see R04
    slot_last_w |-> $past(conv_start_reg, 279))
    else $error("slot did not last 280 system cycles");

  a_conv_clk_half: assert property (@(posedge mclk) disable iff (!rst_n) // see R04
    ($rose(conv_clk_reg) && slot_cnt_reg < 9'h104) |-> ##10 $fell(conv_clk_reg))
    else $error("converter clock half period wrong");

  a_slot_follows: assert property (@(posedge mclk) disable iff (!rst_n) // see R05
    s_slot_open |-> ##279 slot_last_w)
    else $error("slot end missing after slot start");

  a_sel_enabled: assert property (@(posedge mclk) disable iff (!rst_n) // see R05
    in_conv_w |-> scan_mask_reg[chan_sel_reg])
    else $error("disabled channel selected");

  a_chan_range: assert property (@(posedge mclk) disable iff (!rst_n) // see R03
    chan_sel_reg <= CH_LAST)
    else $error("channel select out of range");

  a_round_robin: assert property (@(posedge mclk) disable iff (!rst_n) // see R11
    (slot_last_w && !wrap_w) |=> chan_sel_reg > $past(chan_sel_reg))
    else $error("round robin order broken");

  a_commit_after: assert property (@(posedge mclk) disable iff (!rst_n) // see R01
    s_scan_close |=> (state_reg == ST_COMMIT) ##1 results_updated)
    else $error("results not published after scan end");

  a_commit_cause: assert property (@(posedge mclk) disable iff (!rst_n) // see R06
    results_updated |-> $past(scan_end_w, 2))
    else $error("results published before full averaging");

  a_result_value: assert property (@(posedge mclk) disable iff (!rst_n) // see R12
    (state_reg == ST_COMMIT && scan_mask_reg[0]) |=> result_reg[0] == $past(avg_w[0]))
    else $error("result not the averaged value");

  a_read_result: assert property (@(posedge mclk) disable iff (!rst_n) // see R02
    (rd && addr == OFF_RESULT0) |=> rdata == DATA_W'($past(result_reg[0])))
    else $error("result read wrong");

  a_src_a_follow: assert property (@(posedge mclk) disable iff (!rst_n) // see R07
    wr_ctrl_w |-> ##2 aux_sense_a_src_en == $past(wdata[CTRL_SRC_A_BIT], 2))
    else $error("source a enable not applied");

  a_src_b_level: assert property (@(posedge mclk) disable iff (!rst_n) // see R08
    wr_ctrl_w |-> ##2 aux_sense_b_src_hi == $past(wdata[CTRL_SRC_B_HI_BIT], 2))
    else $error("source b level not applied");

  a_left_flag: assert property (@(posedge mclk) disable iff (!rst_n) // see R09
    left_light_cmp |=> light_reg[0])
    else $error("left light flag not set");

  a_boost_flag: assert property (@(posedge mclk) disable iff (!rst_n) // see R10
    (boost_light_cmp && wr_stat_w) |=> light_reg[2])
    else $error("boost light flag lost to clear");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n) // see R02
    !rd |=> rdata == '0)
    else $error("read data left standing");

  a_busy_scan: assert property (@(posedge mclk) disable iff (!rst_n) // see R05
    in_conv_w |-> scan_busy)
    else $error("busy low while converting");

endmodule : adc_scan_sequencer

// [verif/analog_core_model.sv]
// behavioural analog converter core and input multiplexer
// assumes conv_start opens a 280-cycle slot and the sequencer samples in its last cycle
`timescale 1ns/10ps
module analog_core_model (
  // clock
  input wire logic mclk,
  // converter link
  input wire logic conv_start,
  input wire logic [adc_scan_pkg::SEL_W-1:0] chan_sel,
  output logic [adc_scan_pkg::RES_W-1:0] conv_data,
  // analog levels per channel and offset added on every second sample
  input wire logic [adc_scan_pkg::NCH-1:0][adc_scan_pkg::RES_W-1:0] lvl,
  input wire logic [1:0] wobble
);
  import adc_scan_pkg::*;

  logic [8:0] slot_cyc_reg;
  logic [NCH-1:0] odd_reg;
  logic [SEL_W-1:0] ch_reg;
  wire logic at_end = (slot_cyc_reg == SLOT_LAST);

  initial begin
    slot_cyc_reg = 9'h1FF;
    odd_reg = '0;
    ch_reg = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot timing: 14 converter clocks of 20 system cycles each
  always @(posedge mclk) begin
    if (conv_start) begin
      slot_cyc_reg <= 9'h001;
      ch_reg <= chan_sel;
    end else if (slot_cyc_reg != 9'h1FF) begin
      slot_cyc_reg <= slot_cyc_reg + 9'h001;
    end
    if (at_end) begin
      odd_reg[ch_reg] <= ~odd_reg[ch_reg];
    end
  end

  // result valid only in the last slot cycle, a moving pattern otherwise
  assign conv_data = at_end ? lvl[ch_reg] + (odd_reg[ch_reg] ? 10'(wobble) : 10'h000)
                            : 10'(slot_cyc_reg) ^ 10'h2AA;

endmodule : analog_core_model

// [verif/tb.sv]
// self-checking bench for the converter scan sequencer
// assumes the package and sequencer under core/ and the analog model beside this file
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  import adc_scan_pkg::*;

  logic mclk, rst_n, wr, rd, conv_clk, conv_start, src_a, src_b, src_hi, busy, upd, rd_d, arm, done_flag, conv_clk_d;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [SEL_W-1:0] chan_sel;
  logic [RES_W-1:0] conv_data;
  logic [2:0] cmp;
  logic [NCH-1:0][RES_W-1:0] lvl;
  logic [1:0] wobble;
  logic [6:0] m7;
  logic [DATA_W-1:0] exp_q[$];
  logic [SEL_W-1:0] sel_q[$];
  logic [RES_W-1:0] exp_res [NCH];
  int num_errors, tests_run, cyc, seed, t_start, rises;

  adc_scan_sequencer i_adc_scan_sequencer (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .conv_clk(conv_clk), .conv_start(conv_start), .chan_sel(chan_sel),
    .conv_data(conv_data), .aux_sense_a_src_en(src_a), .aux_sense_b_src_en(src_b),
    .aux_sense_b_src_hi(src_hi), .left_light_cmp(cmp[0]), .right_light_cmp(cmp[1]),
    .boost_light_cmp(cmp[2]), .scan_busy(busy), .results_updated(upd));

  analog_core_model i_analog_core_model (.mclk(mclk), .conv_start(conv_start), .chan_sel(chan_sel),
    .conv_data(conv_data), .lvl(lvl), .wobble(wobble));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // watcher: read data and channel order against the oldest notes
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rd_d <= rd;
    conv_clk_d <= conv_clk;
    if (conv_clk && !conv_clk_d) rises <= rises + 1;
    if (rd_d) `CHK(rdata, exp_q.pop_front())
    if (conv_start) `CHK(chan_sel, sel_q.pop_front())
    if (conv_start && arm) begin
      t_start <= cyc;
      arm <= 1'b0;
    end
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus and scan tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rd_chk

  function automatic logic [15:0] stat(input logic b);
    return {11'h000, done_flag, 3'h0, b};
  endfunction : stat

  task automatic run_scan(input logic [6:0] mask, input int sh, input logic [1:0] w);
    int n, k, r0;
    k = $countones(mask);
    r0 = rises;
    for (int p = 0; p < (1 << sh); p++)
      for (int c = 0; c < NCH; c++)
        if (mask[c]) sel_q.push_back(3'(c));
    for (int c = 0; c < NCH; c++) lvl[c] <= 10'($unsigned($random(seed)) % 1000);
    wobble <= w;
    arm = 1'b1;
    bus(1'b1, OFF_CHAN_EN, {9'h000, mask});
    bus(1'b1, OFF_AVG, 16'(sh));
    bus(1'b1, OFF_CTRL, 16'h0001);
    bus(1'b1, OFF_CTRL, 16'h0000);
    repeat (300) @(posedge mclk);
    `CHK(busy, 1'b1)
    rd_chk(OFF_RESULT0, {6'h00, exp_res[0]});
    rd_chk(OFF_STATUS, stat(1'b1));
    n = 0;
    while (upd !== 1'b1 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    `CHK(cyc - t_start, k * (1 << sh) * SLOT_MCLK + 1)
    `CHK(rises - r0, k * (1 << sh) * SLOT_CONV_CYCLES)
    `CHK(sel_q.size(), 0)
    for (int c = 0; c < NCH; c++)
      if (mask[c]) exp_res[c] = 10'(((1 << sh) * lvl[c] + w * ((1 << sh) / 2)) >> sh);
    done_flag = 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(busy, 1'b0)
    rd_chk(OFF_STATUS, stat(1'b0));
    for (int c = 0; c < NCH; c++) rd_chk(OFF_RESULT0 + 8'(c), {6'h00, exp_res[c]});
  endtask : run_scan

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    {wr, rd, rd_d, arm, done_flag, conv_clk_d} = 6'h00;
    addr = 8'h00;
    wdata = 16'h0000;
    cmp = 3'h0;
    lvl = '0;
    wobble = 2'h0;
    m7 = 7'h00;
    {num_errors, tests_run, cyc, t_start, rises} = '0;
    seed = 78;
    for (int c = 0; c < NCH; c++) exp_res[c] = 10'h000;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    `CHK({src_a, src_b, src_hi, busy, upd, conv_start, conv_clk}, 7'h00)
    rd_chk(OFF_CTRL, 16'h0000);
    rd_chk(OFF_CHAN_EN, 16'h007F);
    rd_chk(OFF_AVG, 16'h0000);
    rd_chk(OFF_STATUS, 16'h0000);
    bus(1'b1, 8'h0F, 16'hFFFF);
    rd_chk(8'h0F, 16'h0000);
    for (int c = 0; c < NCH; c++) rd_chk(OFF_RESULT0 + 8'(c), 16'h0000);
    // every source setting, read back as well
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, OFF_CTRL, 16'(m << 1));
      repeat (3) @(posedge mclk);
      `CHK({src_hi, src_b, src_a}, 3'(m))
      rd_chk(OFF_CTRL, 16'(m << 1));
    end
    // light-load flags: set, clear, and set winning over clear
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      cmp <= 3'(1 << i);
      @(posedge mclk);
      cmp <= 3'h0;
      rd_chk(OFF_STATUS, 16'(2 << i));
      bus(1'b1, OFF_STATUS, 16'(2 << i));
      rd_chk(OFF_STATUS, 16'h0000);
      // comparator high only at the clearing edge
      fork
        bus(1'b1, OFF_STATUS, 16'h001F);
        begin
          @(posedge mclk);
          cmp <= 3'(1 << i);
          @(posedge mclk);
          cmp <= 3'h0;
        end
      join
      rd_chk(OFF_STATUS, 16'(2 << i));
      @(posedge mclk);
      cmp <= 3'h0;
      bus(1'b1, OFF_STATUS, 16'h001E);
      rd_chk(OFF_STATUS, 16'h0000);
    end
    // scans: all channels single sample, random subset of four samples, one channel of 128
    run_scan(7'h7F, 0, 2'h0);
    m7 = 7'($random(seed)) | 7'h10;
    run_scan(m7, 2, 2'h1);
    run_scan(7'h08, 7, 2'h3);
    bus(1'b1, OFF_STATUS, 16'h0010);
    done_flag = 1'b0;
    rd_chk(OFF_STATUS, 16'h0000);
    repeat (3) @(posedge mclk);
    test_done();
  end

endmodule : tb
